// ==== design/fwc_ctrl.v ====
// Threshold, release-delay, calibration-source and pulse-interface control
`timescale 1ns/10ps
`include "fwc_consts.vh"
module fwc_ctrl #(
	parameter DLY_W = 16,
	parameter WIDTH_W = 32,
	parameter MEAS_PER_SEC = 8
) (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Measurement side
	input wire recall,
	input wire meas_done,
	input wire meas_error,
	input wire nowater_error,
	input wire [31:0] flow_lph,
	input wire [DLY_W-1:0] first_hit_up,
	input wire [DLY_W-1:0] first_hit_dn,
	input wire [DLY_W-1:0] ref_period,
	input wire [31:0] first_hit_threshold,
	input wire [15:0] flow_temp,
	input wire [15:0] hot_temp,
	// Control outputs
	output reg [1:0] threshold_method_field,
	output reg threshold_ratio_select,
	output reg zero_flow_during_regulation,
	output reg release_window_mode,
	output reg test_mode_due,
	output reg pwr_reg_due,
	output reg [DLY_W-1:0] upstream_release_delay_reg,
	output reg [DLY_W-1:0] downstream_release_delay_reg,
	output reg [15:0] cal_temp,
	output reg [31:0] flow_limited,
	output reg max_flow_error,
	output reg [31:0] pulse_port_control,
	output reg [31:0] general_pin_control,
	// Pulse interface
	output wire pulse_out,
	output wire dir_out,
	// Interrupt
	output wire irq
);
	// Widened to 64 bits first, the clock-hour product overflows 32
	localparam [63:0] WIDTH_NUM = 64'h1 * `FWC_CLK_HZ * `FWC_SEC_PER_HOUR / 64'h4;
	localparam [63:0] VOL_STEP = `FWC_SEC_PER_HOUR * MEAS_PER_SEC;

	// Software-written images
	reg [31:0] pw_nom_r, ppl_r, maxflow_r, rls_nom_r, rls_lim_r, start_thr_r;
	reg [31:0] pulse_img_r, gpin_img_r, usm_img_r, fw_cfg_r;
	reg [`FWC_IRQ_W-1:0] irq_stat_r, irq_mask_r;
	// Active copies taken at recall
	reg [31:0] pw_nom_a, ppl_a, maxflow_a, rls_lim_a, pulse_img_a;
	reg no_pi_err_a, pi_nowater_a, testmode_a, tsens_a;
	reg [4:0] cyc_r;
	reg err_sig_r;
	reg clamp_hit;
	reg calc_start_r;
	reg [63:0] vol_acc_r;
	reg pulse_req_r;
	wire [WIDTH_W-1:0] width;
	wire [`FWC_IRQ_W-1:0] irq_set;
	wire [32:0] max_flow_x2 = {maxflow_a, 1'b0};
	wire err_now = meas_error | (pi_nowater_a & nowater_error);
	// Limit and volume of the measurement now at hand, no one-sample lag
	wire over_now = {1'b0, flow_lph} > max_flow_x2;
	wire [31:0] flow_lim_now = over_now ? max_flow_x2[31:0] : flow_lph;
	wire [63:0] acc_sum = vol_acc_r + flow_lim_now * ppl_a;
	// Width divisor saturates rather than wrapping into a long pulse
	wire [63:0] flow_scale = maxflow_a * ppl_a;
	wire [31:0] div_in = (flow_scale[63:32] != 32'h00000000) ? 32'hffffffff : flow_scale[31:0];

	// Limit realignment and clamp, used for both directions
	function [DLY_W-1:0] lim_min;
		input [31:0] lim;
		lim_min = lim[DLY_W-1-`FWC_LIM_SHIFT:0] << `FWC_LIM_SHIFT;
	endfunction

	function [DLY_W-1:0] lim_max;
		input [31:0] lim;
		lim_max = lim[16+DLY_W-1-`FWC_LIM_SHIFT:16] << `FWC_LIM_SHIFT;
	endfunction

	function [DLY_W:0] place_window;
		input [DLY_W-1:0] hit;
		input [DLY_W-1:0] tref;
		input filt;
		input [31:0] lim;
		reg [DLY_W+3:0] lead;
		reg [DLY_W:0] raw;
		begin
			lead = {4'h0, tref} * (filt ? `FWC_LEAD_Q_FILTER : `FWC_LEAD_Q_PLAIN) >> 2;
			raw = ({4'h0, hit} > lead) ? {1'b0, hit} - lead[DLY_W:0] : {(DLY_W+1){1'b0}};
			if (raw < {1'b0, lim_min(lim)})
				place_window = {1'b1, lim_min(lim)};
			else if (raw > {1'b0, lim_max(lim)})
				place_window = {1'b1, lim_max(lim)};
			else
				place_window = {1'b0, raw[DLY_W-1:0]};
		end
	endfunction

	function [DLY_W-1:0] lim_avg;
		input [31:0] lim;
		reg [DLY_W:0] s;
		begin
			s = {1'b0, lim_min(lim)} + {1'b0, lim_max(lim)};
			lim_avg = s[DLY_W:1];
		end
	endfunction

	wire [DLY_W:0] win_up = place_window(first_hit_up, ref_period, first_hit_threshold != 32'h00000000, rls_lim_a);
	wire [DLY_W:0] win_dn = place_window(first_hit_dn, ref_period, first_hit_threshold != 32'h00000000, rls_lim_a);

	// Register writes
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pw_nom_r <= 32'h00000000;
			ppl_r <= 32'h00000000;
			maxflow_r <= 32'h00000000;
			rls_nom_r <= 32'h00000000;
			rls_lim_r <= 32'h00000000;
			start_thr_r <= 32'h00000000;
			pulse_img_r <= 32'h00000000;
			gpin_img_r <= 32'h00000000;
			usm_img_r <= 32'h00000000;
			fw_cfg_r <= 32'h00000000;
			irq_mask_r <= {`FWC_IRQ_W{1'b0}};
		end else if (reg_wr) begin
			case (reg_addr)
				`FWC_OFS_PW_NOM: pw_nom_r <= reg_wdata;
				`FWC_OFS_PPL: ppl_r <= reg_wdata;
				`FWC_OFS_MAXFLOW: maxflow_r <= reg_wdata;
				`FWC_OFS_RLS_NOM: rls_nom_r <= reg_wdata;
				`FWC_OFS_RLS_LIM: rls_lim_r <= reg_wdata;
				`FWC_OFS_START_THR: start_thr_r <= reg_wdata;
				`FWC_OFS_PULSE_IMG: pulse_img_r <= reg_wdata;
				`FWC_OFS_GPIN_IMG: gpin_img_r <= reg_wdata;
				`FWC_OFS_USM_IMG: usm_img_r <= reg_wdata;
				`FWC_OFS_FW_CFG: fw_cfg_r <= reg_wdata;
				`FWC_OFS_IRQ_MASK: irq_mask_r <= reg_wdata[`FWC_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Recall: take configuration into active copies
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pw_nom_a <= 32'h00000000;
			ppl_a <= 32'h00000000;
			maxflow_a <= 32'h00000000;
			rls_lim_a <= 32'h00000000;
			pulse_img_a <= 32'h00000000;
			no_pi_err_a <= 1'b1;
			pi_nowater_a <= 1'b0;
			testmode_a <= 1'b0;
			tsens_a <= 1'b0;
			threshold_method_field <= 2'h0;
			threshold_ratio_select <= 1'b0;
			zero_flow_during_regulation <= 1'b0;
			release_window_mode <= 1'b0;
			general_pin_control <= 32'h00000000;
			calc_start_r <= 1'b0;
		end else begin
			calc_start_r <= recall;
			if (recall) begin
				pw_nom_a <= pw_nom_r;
				ppl_a <= ppl_r;
				maxflow_a <= maxflow_r;
				rls_lim_a <= rls_lim_r;
				pulse_img_a <= pulse_img_r;
				no_pi_err_a <= fw_cfg_r[`FWC_B_NO_PI_ERR];
				pi_nowater_a <= fw_cfg_r[`FWC_B_PI_NOWATER];
				testmode_a <= fw_cfg_r[`FWC_B_TESTMODE];
				tsens_a <= fw_cfg_r[`FWC_B_TSENS];
				threshold_method_field <= fw_cfg_r[`FWC_B_METHOD_LO+1:`FWC_B_METHOD_LO];
				threshold_ratio_select <= fw_cfg_r[`FWC_B_RATIO];
				zero_flow_during_regulation <= fw_cfg_r[`FWC_B_ZEROFLOW];
				release_window_mode <= usm_img_r[`FWC_B_RLY_MODE];
				general_pin_control <= gpin_img_r;
			end
		end
	end

	// Regulation cadence: test mode at 0, width ratio at 16
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cyc_r <= 5'h00;
			test_mode_due <= 1'b0;
			pwr_reg_due <= 1'b0;
		end else begin
			test_mode_due <= 1'b0;
			pwr_reg_due <= 1'b0;
			if (recall) begin
				cyc_r <= 5'h00;
			end else if (meas_done) begin
				cyc_r <= (cyc_r == `FWC_REG_PERIOD) ? 5'h00 : cyc_r + 5'h01;
				test_mode_due <= testmode_a ? (cyc_r == 5'h00) : meas_error;
				pwr_reg_due <= (pw_nom_a != 32'h00000000) && (cyc_r == `FWC_PWR_OFFSET);
			end
		end
	end

	// Release delays: nominal (limit average if nominal is zero) at recall, windowed updates after
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			upstream_release_delay_reg <= {DLY_W{1'b0}};
			downstream_release_delay_reg <= {DLY_W{1'b0}};
			clamp_hit <= 1'b0;
		end else begin
			clamp_hit <= 1'b0;
			if (recall) begin
				if (rls_nom_r != 32'h00000000) begin
					upstream_release_delay_reg <= rls_nom_r[DLY_W-1:0];
					downstream_release_delay_reg <= rls_nom_r[DLY_W-1:0];
				end else begin
					upstream_release_delay_reg <= lim_avg(rls_lim_r);
					downstream_release_delay_reg <= lim_avg(rls_lim_r);
				end
			end else if (meas_done && !meas_error && release_window_mode) begin
				upstream_release_delay_reg <= win_up[DLY_W-1:0];
				downstream_release_delay_reg <= win_dn[DLY_W-1:0];
				clamp_hit <= win_up[DLY_W] | win_dn[DLY_W];
			end
		end
	end

	// Calibration temperature, flow limit, pulse volume
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cal_temp <= 16'h0000;
			flow_limited <= 32'h00000000;
			max_flow_error <= 1'b0;
			err_sig_r <= 1'b0;
			vol_acc_r <= 64'h0000000000000000;
			pulse_req_r <= 1'b0;
			pulse_port_control <= 32'h00000000;
		end else begin
			pulse_req_r <= 1'b0;
			pulse_port_control <= (pulse_img_a & `FWC_PPC_KEEP_MASK) | {16'h0000, width[15:0]};
			if (recall) begin
				vol_acc_r <= 64'h0000000000000000;
				err_sig_r <= 1'b0;
			end else if (meas_done) begin
				cal_temp <= tsens_a ? hot_temp : flow_temp;
				if (over_now) begin
					flow_limited <= max_flow_x2[31:0];
					max_flow_error <= 1'b1;
				end else begin
					flow_limited <= flow_lph;
					max_flow_error <= 1'b0;
				end
				err_sig_r <= !no_pi_err_a && err_now;
				if (!err_now && acc_sum >= VOL_STEP) begin
					vol_acc_r <= acc_sum - VOL_STEP;
					pulse_req_r <= 1'b1;
				end else if (!err_now) begin
					vol_acc_r <= acc_sum;
				end
			end
		end
	end

	// Sticky status, write one to clear, set wins
	assign irq_set = {clamp_hit, test_mode_due, err_sig_r, over_now & meas_done};
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			irq_stat_r <= {`FWC_IRQ_W{1'b0}};
		else if (reg_wr && reg_addr == `FWC_OFS_IRQ_STAT)
			irq_stat_r <= (irq_stat_r & ~reg_wdata[`FWC_IRQ_W-1:0]) | irq_set;
		else
			irq_stat_r <= irq_stat_r | irq_set;
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	// Read data one cycle after strobe
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`FWC_OFS_PW_NOM: reg_rdata <= pw_nom_r;
				`FWC_OFS_PPL: reg_rdata <= ppl_r;
				`FWC_OFS_MAXFLOW: reg_rdata <= maxflow_r;
				`FWC_OFS_RLS_NOM: reg_rdata <= rls_nom_r;
				`FWC_OFS_RLS_LIM: reg_rdata <= rls_lim_r;
				`FWC_OFS_START_THR: reg_rdata <= start_thr_r;
				`FWC_OFS_PULSE_IMG: reg_rdata <= pulse_img_r;
				`FWC_OFS_GPIN_IMG: reg_rdata <= gpin_img_r;
				`FWC_OFS_USM_IMG: reg_rdata <= usm_img_r;
				`FWC_OFS_FW_CFG: reg_rdata <= fw_cfg_r;
				`FWC_OFS_IRQ_STAT: reg_rdata <= {{(32-`FWC_IRQ_W){1'b0}}, irq_stat_r};
				`FWC_OFS_IRQ_MASK: reg_rdata <= {{(32-`FWC_IRQ_W){1'b0}}, irq_mask_r};
				`FWC_OFS_STATUS: reg_rdata <= {24'h000000, err_sig_r, max_flow_error, cyc_r, release_window_mode};
				`FWC_OFS_RLS_UP: reg_rdata <= {{(32-DLY_W){1'b0}}, upstream_release_delay_reg};
				`FWC_OFS_RLS_DN: reg_rdata <= {{(32-DLY_W){1'b0}}, downstream_release_delay_reg};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Width: quarter of the pulse period at maximum flow, no double pulse
	fwc_pulse_gen #(
		.WIDTH_W(WIDTH_W)
	) u_pulse (
		.core_clk(core_clk),
		.nrst(nrst),
		.calc_start(calc_start_r),
		.dividend(WIDTH_NUM),
		.divisor(div_in),
		.width_r(width),
		.pulse_req(pulse_req_r),
		.meas_tick(meas_done),
		.err_sig(err_sig_r),
		.pulse_out_r(pulse_out),
		.dir_out_r(dir_out)
	);
endmodule // fwc_ctrl

// ==== design/fwc_consts.vh ====
// Offsets, field positions and timing counts of the flow-control block
`ifndef FWC_CONSTS_VH
`define FWC_CONSTS_VH
// Register offsets
`define FWC_OFS_PW_NOM 8'h56
`define FWC_OFS_PPL 8'h5b
`define FWC_OFS_MAXFLOW 8'h5c
`define FWC_OFS_RLS_NOM 8'h67
`define FWC_OFS_RLS_LIM 8'h69
`define FWC_OFS_START_THR 8'h6b
`define FWC_OFS_PULSE_IMG 8'h6d
`define FWC_OFS_GPIN_IMG 8'h6e
`define FWC_OFS_FW_CFG 8'h70
`define FWC_OFS_IRQ_STAT 8'h71
`define FWC_OFS_IRQ_MASK 8'h72
`define FWC_OFS_STATUS 8'h73
`define FWC_OFS_USM_IMG 8'h74
`define FWC_OFS_RLS_UP 8'h75
`define FWC_OFS_RLS_DN 8'h76
// Firmware config word fields
`define FWC_B_ZEROFLOW 17
`define FWC_B_NO_PI_ERR 21
`define FWC_B_PI_NOWATER 22
`define FWC_B_TESTMODE 23
`define FWC_B_METHOD_LO 24
`define FWC_B_RATIO 26
`define FWC_B_TSENS 30
// Process control field
`define FWC_B_RLY_MODE 19
// Limit realignment and lead distances in quarter periods
`define FWC_LIM_SHIFT 3
`define FWC_LEAD_Q_PLAIN 16'd1
`define FWC_LEAD_Q_FILTER 16'd9
// Regulation cadence
`define FWC_REG_PERIOD 5'd31
`define FWC_PWR_OFFSET 5'd16
// Interrupt status bits
`define FWC_IRQ_MAXFLOW 0
`define FWC_IRQ_PIERR 1
`define FWC_IRQ_TEST 2
`define FWC_IRQ_CLAMP 3
`define FWC_IRQ_W 4
// Pulse control override: low half of the image carries computed width
`define FWC_PPC_KEEP_MASK 32'hffff0000
// Timing
`define FWC_CLK_HZ 40000000
`define FWC_MIN_PULSE_PERIOD_MS 10
`define FWC_SEC_PER_HOUR 3600
`endif

// ==== design/fwc_pulse_gen.v ====
// Pulse output generator with width divider and error signalling
`timescale 1ns/10ps
module fwc_pulse_gen #(
	parameter WIDTH_W = 32
) (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Width computation
	input wire calc_start,
	input wire [63:0] dividend,
	input wire [31:0] divisor,
	output reg [WIDTH_W-1:0] width_r,
	// Pulse requests and error
	input wire pulse_req,
	input wire meas_tick,
	input wire err_sig,
	output reg pulse_out_r,
	output reg dir_out_r
);
	reg [63:0] rem_r;
	reg [63:0] quo_r;
	reg [6:0] step_r;
	reg [WIDTH_W-1:0] cnt_r;
	wire [63:0] div_ext = {32'h00000000, divisor};
	wire [63:0] trial = {rem_r[62:0], quo_r[63]};

	// Restoring divider, one quotient bit per cycle
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rem_r <= 64'h0000000000000000;
			quo_r <= 64'h0000000000000000;
			step_r <= 7'h00;
			width_r <= {WIDTH_W{1'b0}};
		end else if (calc_start) begin
			rem_r <= 64'h0000000000000000;
			quo_r <= dividend;
			step_r <= (divisor == 32'h00000000) ? 7'h00 : 7'h40;
		end else if (step_r != 7'h00) begin
			step_r <= step_r - 7'h01;
			if (trial >= div_ext) begin
				rem_r <= trial - div_ext;
				quo_r <= {quo_r[62:0], 1'b1};
			end else begin
				rem_r <= trial;
				quo_r <= {quo_r[62:0], 1'b0};
			end
			if (step_r == 7'h01)
				width_r <= (quo_r[62:WIDTH_W-1] != 0) ? {WIDTH_W{1'b1}} :
					{quo_r[WIDTH_W-2:0], trial >= div_ext};
		end
	end

	// Error holds pulse high and toggles direction per measurement
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pulse_out_r <= 1'b0;
			dir_out_r <= 1'b0;
			cnt_r <= {WIDTH_W{1'b0}};
		end else if (err_sig) begin
			pulse_out_r <= 1'b1;
			cnt_r <= {WIDTH_W{1'b0}};
			if (meas_tick)
				dir_out_r <= ~dir_out_r;
		end else if (cnt_r != {WIDTH_W{1'b0}}) begin
			cnt_r <= cnt_r - {{(WIDTH_W-1){1'b0}}, 1'b1};
			pulse_out_r <= (cnt_r != {{(WIDTH_W-1){1'b0}}, 1'b1});
		end else if (pulse_req) begin
			cnt_r <= (width_r == {WIDTH_W{1'b0}}) ? {{(WIDTH_W-1){1'b0}}, 1'b1} : width_r;
			pulse_out_r <= 1'b1;
			dir_out_r <= 1'b0;
		end else begin
			pulse_out_r <= 1'b0;
			dir_out_r <= 1'b0;
		end
	end
endmodule // fwc_pulse_gen

// ==== test/fwc_ctrl_monitor.sv ====
// Concurrent checks on the flow control block ports
`timescale 1ns/10ps
`include "fwc_consts.vh"
module fwc_ctrl_mon #(
	parameter DLY_W = 16
) (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Measurement side
	input wire recall,
	input wire meas_done,
	input wire meas_error,
	// Watched outputs
	input wire [1:0] threshold_method_field,
	input wire release_window_mode,
	input wire test_mode_due,
	input wire [DLY_W-1:0] upstream_release_delay_reg,
	input wire [DLY_W-1:0] downstream_release_delay_reg,
	input wire pulse_out,
	input wire dir_out,
	input wire irq
);
	reg [31:0] cfg_r;
	reg [31:0] act_r;
	reg usm_r;
	reg seen_r;
	// Shadow of written and recalled configuration
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_r <= 32'h0;
			act_r <= 32'h0;
			usm_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `FWC_OFS_FW_CFG)
				cfg_r <= reg_wdata;
			if (reg_wr && reg_addr == `FWC_OFS_USM_IMG)
				usm_r <= reg_wdata[`FWC_B_RLY_MODE];
			if (recall)
				act_r <= cfg_r;
			if (recall)
				seen_r <= 1'b1;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside answer cycle");
	method_take_a: assert property (recall |=> threshold_method_field == $past(cfg_r[25:24]))
		else $error("method not taken at recall");
	method_hold_a: assert property (!recall |=> $stable(threshold_method_field))
		else $error("method changed without recall");
	window_mode_a: assert property (recall |=> release_window_mode == $past(usm_r))
		else $error("window mode not taken at recall");
	test_on_err_a: assert property (seen_r && meas_done && meas_error && !act_r[`FWC_B_TESTMODE] |=> test_mode_due)
		else $error("no test entry after error");
	test_cause_a: assert property (test_mode_due |-> $past(meas_done))
		else $error("test entry without measurement");
	pulse_err_a: assert property (seen_r && meas_done && meas_error && !act_r[`FWC_B_NO_PI_ERR] |-> ##2 pulse_out [*3])
		else $error("pulse output not held on error");
	dir_quiet_a: assert property (dir_out != $past(dir_out) |-> !$past(act_r[`FWC_B_NO_PI_ERR], 2))
		else $error("direction toggled while suppressed");
	delay_pair_a: assert property (recall |=> upstream_release_delay_reg == downstream_release_delay_reg)
		else $error("delays differ after recall");
	irq_off_a: assert property (reg_wr && reg_addr == `FWC_OFS_IRQ_MASK && reg_wdata == 32'h0 |=> !irq)
		else $error("interrupt high with all masked");
	// Main scenarios reached
	cover property (recall);
	cover property (seen_r && meas_done && meas_error && !act_r[`FWC_B_NO_PI_ERR]);
	cover property (test_mode_due);
endmodule // fwc_ctrl_mon
bind fwc_ctrl fwc_ctrl_mon #(.DLY_W(DLY_W)) u_fwc_ctrl_mon (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .recall(recall),
	.meas_done(meas_done), .meas_error(meas_error), .threshold_method_field(threshold_method_field),
	.release_window_mode(release_window_mode), .test_mode_due(test_mode_due),
	.upstream_release_delay_reg(upstream_release_delay_reg),
	.downstream_release_delay_reg(downstream_release_delay_reg), .pulse_out(pulse_out), .dir_out(dir_out),
	.irq(irq));

// ==== test/fwc_readout.sv ====
// Readout model tallying pulses and direction toggles
`timescale 1ns/10ps
module fwc_readout (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Pulse interface
	input wire pulse_out,
	input wire dir_out,
	// Tallies
	output reg [15:0] pulse_cnt,
	output reg [15:0] toggle_cnt
);
	reg p_q;
	reg d_q;
	// Count pulse rises and direction changes
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			p_q <= 1'b0;
			d_q <= 1'b0;
			pulse_cnt <= 16'h0;
			toggle_cnt <= 16'h0;
		end else begin
			p_q <= pulse_out;
			d_q <= dir_out;
			if (pulse_out && !p_q)
				pulse_cnt <= pulse_cnt + 16'h1;
			if (dir_out != d_q)
				toggle_cnt <= toggle_cnt + 16'h1;
		end
	end
endmodule // fwc_readout

// ==== test/fwc_ctrl_bench.sv ====
// Self-checking bench for the flow control block
`timescale 1ns/10ps
`include "fwc_consts.vh"
`define FWC_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: %h %h", $time, g, e); end end
module fwc_ctrl_bench;
	reg core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, recall = 1'b0, meas_done = 1'b0, rd_d = 1'b0;
	reg meas_error = 1'b0, nowater_error = 1'b0;
	reg [7:0] reg_addr = 8'h0;
	reg [31:0] reg_wdata = 32'h0, flow_lph = 32'h0, first_hit_threshold = 32'h0, rnd = 32'd4934, x, ev;
	reg [15:0] first_hit_up = 16'h0, first_hit_dn = 16'h0, ref_period = 16'd200;
	reg [15:0] flow_temp = 16'h1111, hot_temp = 16'h2222;
	wire [31:0] reg_rdata, flow_limited, pulse_port_control, general_pin_control;
	wire [15:0] upstream_release_delay_reg, downstream_release_delay_reg, cal_temp, pulse_cnt, toggle_cnt;
	wire [1:0] threshold_method_field;
	wire threshold_ratio_select, zero_flow_during_regulation, release_window_mode, test_mode_due, pwr_reg_due;
	wire max_flow_error, pulse_out, dir_out, irq;
	int n_mismatch = 0, cmp_count = 0, n_test = 0, n_pwr = 0, i;
	logic [31:0] rd_q[$];
	logic [7:0] ofs[9] = '{`FWC_OFS_PW_NOM, `FWC_OFS_PPL, `FWC_OFS_MAXFLOW, `FWC_OFS_RLS_NOM, `FWC_OFS_RLS_LIM,
		`FWC_OFS_START_THR, `FWC_OFS_PULSE_IMG, `FWC_OFS_GPIN_IMG, `FWC_OFS_USM_IMG};
	fwc_ctrl u_fwc_ctrl (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .recall(recall), .meas_done(meas_done),
		.meas_error(meas_error), .nowater_error(nowater_error), .flow_lph(flow_lph), .first_hit_up(first_hit_up),
		.first_hit_dn(first_hit_dn), .ref_period(ref_period), .first_hit_threshold(first_hit_threshold),
		.flow_temp(flow_temp), .hot_temp(hot_temp), .threshold_method_field(threshold_method_field),
		.threshold_ratio_select(threshold_ratio_select), .zero_flow_during_regulation(zero_flow_during_regulation),
		.release_window_mode(release_window_mode), .test_mode_due(test_mode_due), .pwr_reg_due(pwr_reg_due),
		.upstream_release_delay_reg(upstream_release_delay_reg), .cal_temp(cal_temp), .flow_limited(flow_limited),
		.downstream_release_delay_reg(downstream_release_delay_reg), .max_flow_error(max_flow_error),
		.pulse_port_control(pulse_port_control), .general_pin_control(general_pin_control),
		.pulse_out(pulse_out), .dir_out(dir_out), .irq(irq));
	fwc_readout u_fwc_readout (.core_clk(core_clk), .nrst(nrst), .pulse_out(pulse_out), .dir_out(dir_out),
		.pulse_cnt(pulse_cnt), .toggle_cnt(toggle_cnt));
	always #12.5 core_clk = ~core_clk;
	// Take the oldest noted read value when its answer stands
	always @(posedge core_clk) begin
		if (rd_d) begin
			ev = rd_q.pop_front();
			`FWC_CHK(reg_rdata, ev)
		end
		rd_d <= reg_rd;
		if (test_mode_due === 1'b1) n_test++;
		if (pwr_reg_due === 1'b1) n_pwr++;
	end
	function [31:0] xs(input [31:0] v);
		xs = v ^ (v << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	task wr(input [7:0] a, input [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		@(posedge core_clk);
		rd_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	task meas(input err, input nw);
		@(posedge core_clk);
		meas_error <= err;
		nowater_error <= nw;
		meas_done <= 1'b1;
		@(posedge core_clk);
		meas_done <= 1'b0;
		repeat (40) @(posedge core_clk);
		#1;
	endtask
	task rcl;
		@(posedge core_clk);
		recall <= 1'b1;
		@(posedge core_clk);
		recall <= 1'b0;
		repeat (80) @(posedge core_clk);
		#1;
	endtask
	task final_report;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang guard, about four times the expected run
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		// Images read back; unmapped place answers zero
		for (i = 0; i < 9; i++) begin
			rnd = xs(rnd);
			wr(ofs[i], rnd);
			rd(ofs[i], rnd);
		end
		wr(8'h50, rnd);
		rd(8'h50, 32'h0);
		// Each method code taken at recall, later writes ignored
		for (i = 0; i < 4; i++) begin
			rnd = xs(rnd);
			x = {rnd[31:26], i[1:0], rnd[23:0]};
			wr(`FWC_OFS_FW_CFG, x);
			rcl;
			wr(`FWC_OFS_FW_CFG, ~x);
			meas(1'b0, 1'b0);
			`FWC_CHK(threshold_method_field, x[25:24])
			`FWC_CHK(threshold_ratio_select, x[26])
			`FWC_CHK(zero_flow_during_regulation, x[17])
			`FWC_CHK(cal_temp, x[30] ? hot_temp : flow_temp)
		end
		// Limit average, nominal copy, window lead and clamping
		wr(`FWC_OFS_FW_CFG, 32'h0);
		wr(`FWC_OFS_USM_IMG, 32'h0);
		wr(`FWC_OFS_RLS_LIM, {16'd250, 16'd12});
		wr(`FWC_OFS_RLS_NOM, 32'h0);
		rcl;
		rd(`FWC_OFS_RLS_UP, 32'd1048);
		wr(`FWC_OFS_RLS_NOM, 32'h300);
		rcl;
		@(posedge core_clk);
		first_hit_up <= 16'd1000;
		first_hit_dn <= 16'd100;
		meas(1'b0, 1'b0);
		rd(`FWC_OFS_RLS_DN, 32'h300);
		wr(`FWC_OFS_USM_IMG, 32'h80000);
		rcl;
		meas(1'b0, 1'b0);
		`FWC_CHK(upstream_release_delay_reg, 16'd950)
		`FWC_CHK(downstream_release_delay_reg, 16'd96)
		@(posedge core_clk);
		first_hit_threshold <= 32'h1;
		first_hit_up <= 16'd3000;
		first_hit_dn <= 16'd1000;
		meas(1'b0, 1'b0);
		rd(`FWC_OFS_RLS_UP, 32'd2000);
		rd(`FWC_OFS_RLS_DN, 32'd550);
		// Width of twenty cycles, one pulse per measurement
		wr(`FWC_OFS_PPL, 32'd100);
		wr(`FWC_OFS_MAXFLOW, 32'd18000000);
		wr(`FWC_OFS_PULSE_IMG, 32'habcd1234);
		wr(`FWC_OFS_GPIN_IMG, 32'h5a5a);
		rcl;
		`FWC_CHK(pulse_port_control, 32'habcd0014)
		`FWC_CHK(general_pin_control, 32'h5a5a)
		x = pulse_cnt;
		@(posedge core_clk);
		flow_lph <= 32'd288;
		for (i = 0; i < 4; i++)
			meas(1'b0, 1'b0);
		`FWC_CHK(pulse_cnt, x[15:0] + 16'd4)
		@(posedge core_clk);
		flow_lph <= 32'h0;
		// Regular test and width-ratio cadence over 64 measurements
		wr(`FWC_OFS_PW_NOM, 32'h5);
		wr(`FWC_OFS_FW_CFG, 32'ha00000);
		rcl;
		n_test = 0;
		n_pwr = 0;
		for (i = 0; i < 64; i++)
			meas(1'b0, 1'b0);
		`FWC_CHK(n_test, 2)
		`FWC_CHK(n_pwr, 2)
		// Test entry on error only; suppressed port stays quiet
		wr(`FWC_OFS_FW_CFG, 32'h200000);
		rcl;
		n_test = 0;
		x = toggle_cnt;
		meas(1'b1, 1'b0);
		meas(1'b1, 1'b1);
		`FWC_CHK(n_test, 2)
		`FWC_CHK(toggle_cnt, x[15:0])
		`FWC_CHK(pulse_out, 1'b0)
		// No-water joins the error signal only when enabled
		wr(`FWC_OFS_FW_CFG, 32'h400000);
		rcl;
		meas(1'b0, 1'b1);
		x = toggle_cnt;
		meas(1'b0, 1'b1);
		meas(1'b0, 1'b1);
		meas(1'b1, 1'b0);
		`FWC_CHK(pulse_out, 1'b1)
		`FWC_CHK(toggle_cnt, x[15:0] + 16'd3)
		wr(`FWC_OFS_FW_CFG, 32'h0);
		rcl;
		meas(1'b0, 1'b0);
		x = toggle_cnt;
		meas(1'b0, 1'b1);
		`FWC_CHK(toggle_cnt, x[15:0])
		`FWC_CHK(pulse_out, 1'b0)
		// Flow above twice the maximum flow flags, limits, interrupts
		wr(`FWC_OFS_IRQ_MASK, 32'h1);
		@(posedge core_clk);
		flow_lph <= 32'd36000000;
		meas(1'b0, 1'b0);
		`FWC_CHK(max_flow_error, 1'b0)
		`FWC_CHK(irq, 1'b0)
		@(posedge core_clk);
		flow_lph <= 32'd36000001;
		meas(1'b0, 1'b0);
		`FWC_CHK(max_flow_error, 1'b1)
		`FWC_CHK(flow_limited, 32'd36000000)
		`FWC_CHK(irq, 1'b1)
		wr(`FWC_OFS_IRQ_MASK, 32'h0);
		wr(`FWC_OFS_IRQ_MASK, 32'h1);
		`FWC_CHK(irq, 1'b1)
		wr(`FWC_OFS_IRQ_STAT, 32'h1);
		`FWC_CHK(irq, 1'b0)
		repeat (3) @(posedge core_clk);
		final_report;
	end
endmodule // fwc_ctrl_bench
